// [hw/pad_cfg_regs.svh]
// offsets, field positions, reset values for the control-port pad configuration bank
`ifndef PAD_CFG_REGS_SVH
`define PAD_CFG_REGS_SVH

// offsets are register indices; the bus byte address is four times the index
`define IDX_AUDIO_TX_OUT_PAD_CFG 16'hf798
`define IDX_CTRL_SERIAL_CLOCK_PAD_CFG 16'hf799
`define IDX_CTRL_DATA_OUT_PAD_CFG 16'hf79a
`define IDX_CTRL_SELECT_PAD_CFG 16'hf79b
`define IDX_CTRL_DATA_IN_PAD_CFG 16'hf79c
`define IDX_BASE `IDX_AUDIO_TX_OUT_PAD_CFG
`define PAD_REG_COUNT 5

`define RST_AUDIO_TX_OUT_PAD_CFG 16'h0008
`define RST_CTRL_SERIAL_CLOCK_PAD_CFG 16'h0008
`define RST_CTRL_DATA_OUT_PAD_CFG 16'h0008
`define RST_CTRL_SELECT_PAD_CFG 16'h0018
`define RST_CTRL_DATA_IN_PAD_CFG 16'h0018

`define FLD_RSVD_MSB 15
`define FLD_RSVD_LSB 5
`define FLD_PULL_BIT 4
`define FLD_SLEW_MSB 3
`define FLD_SLEW_LSB 2
`define FLD_DRIVE_MSB 1
`define FLD_DRIVE_LSB 0

`endif

// [hw/pad_cfg_pkg.sv]
// types for the control-port pad configuration bank
package pad_cfg_pkg;
    typedef enum logic [1:0] {
        SLEW_SLOWEST,
        SLEW_SLOW,
        SLEW_FAST,
        SLEW_FASTEST
    } slew_t;

    typedef enum logic [1:0] {
        DRIVE_LOWEST,
        DRIVE_LOW,
        DRIVE_HIGH,
        DRIVE_HIGHEST
    } drive_t;
endpackage : pad_cfg_pkg

// [hw/pad_cfg_cell.sv]
// one 16-bit pad configuration register with decoded outputs
`timescale 1ns/1ns
`include "pad_cfg_regs.svh"
module pad_cfg_cell #(
    parameter logic [15:0] RESET_VALUE = 16'h0008
) (
    input wire logic clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic writeEn, // accepted write to this register
    input wire logic [15:0] writeData, // value to store
    output logic [15:0] value, // stored register contents
    output logic pullEn, // pull resistor enable
    output pad_cfg_pkg::slew_t slewSel, // slew rate selection
    output pad_cfg_pkg::drive_t driveSel // drive strength selection
);
    import pad_cfg_pkg::*;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            value <= RESET_VALUE;
        end else if (writeEn) begin
            value <= writeData;
        end
    end

    // reserved bits are stored for readback but steer nothing
    assign pullEn = value[`FLD_PULL_BIT];
    assign slewSel = slew_t'(value[`FLD_SLEW_MSB:`FLD_SLEW_LSB]);
    assign driveSel = drive_t'(value[`FLD_DRIVE_MSB:`FLD_DRIVE_LSB]);
endmodule : pad_cfg_cell

// [hw/control_port_pad_config_regs.sv]
// APB register bank holding pad settings for the transmitter and control-port pins
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`include "pad_cfg_regs.svh"

////////////////////////////////////////////////////////////////////////////////

// Overview of operation
// - transmitter pad register at 0xF798, reset 0x0008
// - serial clock pad register at 0xF799, reset 0x0008
// - data-out pad register at 0xF79A, reset 0x0008
// - select pad register at 0xF79B, reset 0x0018
// - data-in pad register at 0xF79C, reset 0x0018
// - 16 bits: reserved, pull, slew, drive fields
// - slew codes slowest to fastest, reset 2
// - drive codes lowest to highest, reset 0
// - transmitter pull bit enables pull-down, reset off
// - serial clock pull bit enables pull-up, off
// - data-out pull bit enables pull-up, off
// - select pull bit enables pull-up, on
// - data-in pull bit enables pull-up, on
// - reserved bits reset zero, store, no effect
module control_port_pad_config_regs #(
    parameter int ADDR_WIDTH = 18,
    parameter bit TX_PRESENT = 1'b1
) (
    input wire logic clk, // 100 MHz system clock
    input wire logic reset, // async reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high for write
    input wire logic [ADDR_WIDTH-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic audio_tx_out_pin_pulldown_en, // transmitter pull-down enable
    output pad_cfg_pkg::slew_t audio_tx_out_pin_slew_sel, // transmitter slew
    output pad_cfg_pkg::drive_t audio_tx_out_pin_drive_sel, // transmitter drive
    output logic ctrl_sclk_pullup_en, // serial clock pull-up enable
    output pad_cfg_pkg::slew_t ctrl_sclk_slew_sel, // serial clock slew
    output pad_cfg_pkg::drive_t ctrl_sclk_drive_sel, // serial clock drive
    output logic ctrl_dout_pullup_en, // data-out pull-up enable
    output pad_cfg_pkg::slew_t ctrl_dout_slew_sel, // data-out slew
    output pad_cfg_pkg::drive_t ctrl_dout_drive_sel, // data-out drive
    output logic device_address_bit_zero_pullup_en, // select pull-up enable
    output pad_cfg_pkg::slew_t device_address_bit_zero_slew_sel, // select slew
    output pad_cfg_pkg::drive_t device_address_bit_zero_drive_sel, // select drive
    output logic ctrl_din_pullup_en, // data-in pull-up enable
    output pad_cfg_pkg::slew_t ctrl_din_slew_sel, // data-in slew
    output pad_cfg_pkg::drive_t ctrl_din_drive_sel // data-in drive
);
    import pad_cfg_pkg::*;

    localparam int NREG = `PAD_REG_COUNT;
    localparam logic [15:0] RESETS [NREG] = '{
        `RST_AUDIO_TX_OUT_PAD_CFG,
        `RST_CTRL_SERIAL_CLOCK_PAD_CFG,
        `RST_CTRL_DATA_OUT_PAD_CFG,
        `RST_CTRL_SELECT_PAD_CFG,
        `RST_CTRL_DATA_IN_PAD_CFG
    };

    ////////////////////////////////////////////////////////////////////////////

    // map a byte address to a slot; returns NREG when nothing is there
    function automatic logic [2:0] decodeSlot(input logic [ADDR_WIDTH-1:0] addr);
        logic [ADDR_WIDTH-3:0] idx;
        logic [15:0] wideIdx;
        logic [15:0] delta;
        idx = addr[ADDR_WIDTH-1:2];
        wideIdx = 16'(idx);
        delta = wideIdx - `IDX_BASE;
        decodeSlot = 3'(NREG);
        if (addr[1:0] == 2'h0 && wideIdx >= `IDX_BASE && delta < 16'(NREG)) begin
            decodeSlot = delta[2:0];
        end
        // transmitter pin absent on some variants: its slot is unmapped
        if (!TX_PRESENT && decodeSlot == 3'h0) begin
            decodeSlot = 3'(NREG);
        end
    endfunction : decodeSlot

    logic [2:0] slot;
    logic hit;
    logic accessPhase;
    logic [15:0] mergedData;
    logic [15:0] value [NREG];
    logic pull [NREG];
    slew_t slew [NREG];
    drive_t drive [NREG];

    assign slot = decodeSlot(paddr);
    assign hit = (slot < 3'(NREG));
    assign accessPhase = psel && penable;

    // zero-wait slave: every access completes in its first access cycle
    assign pready = accessPhase;
    assign pslverr = accessPhase && !hit;

    ////////////////////////////////////////////////////////////////////////////

    // byte strobes merge into the current value; upper lanes fall outside 16 bits
    always_comb begin
        mergedData = hit ? value[slot] : 16'h0000;
        if (pstrb[0]) begin
            mergedData[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            mergedData[15:8] = pwdata[15:8];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_cell
            pad_cfg_cell #(
                .RESET_VALUE(RESETS[g])
            ) u_cell (
                .clk(clk),
                .reset(reset),
                .writeEn(accessPhase && pwrite && hit && slot == 3'(g)),
                .writeData(mergedData),
                .value(value[g]),
                .pullEn(pull[g]),
                .slewSel(slew[g]),
                .driveSel(drive[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////

    // read data registered so data outputs come from flip-flops
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {16'h0000, (hit ? value[slot] : 16'h0000)};
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // pads follow stored fields continuously, except the transmitter pull-down, which is held off when TX_PRESENT is 0
    assign audio_tx_out_pin_pulldown_en = TX_PRESENT && pull[0];
    assign audio_tx_out_pin_slew_sel = slew[0];
    assign audio_tx_out_pin_drive_sel = drive[0];
    assign ctrl_sclk_pullup_en = pull[1];
    assign ctrl_sclk_slew_sel = slew[1];
    assign ctrl_sclk_drive_sel = drive[1];
    assign ctrl_dout_pullup_en = pull[2];
    assign ctrl_dout_slew_sel = slew[2];
    assign ctrl_dout_drive_sel = drive[2];
    assign device_address_bit_zero_pullup_en = pull[3];
    assign device_address_bit_zero_slew_sel = slew[3];
    assign device_address_bit_zero_drive_sel = drive[3];
    assign ctrl_din_pullup_en = pull[4];
    assign ctrl_din_slew_sel = slew[4];
    assign ctrl_din_drive_sel = drive[4];
endmodule : control_port_pad_config_regs

// [sim/pad_cfg_sva.sv]
// assertions on the ports of the pad configuration bank
`timescale 1ns/1ns
module pad_cfg_sva #(
    parameter int ADDR_WIDTH = 18
) (
    input logic clk, // clock
    input logic reset, // reset
    input logic psel, // select
    input logic penable, // access phase
    input logic pwrite, // direction
    input logic [ADDR_WIDTH-1:0] paddr, // address
    input logic [31:0] pwdata, // write data
    input logic [3:0] pstrb, // strobes
    input logic pready, // ready
    input logic pslverr, // error
    input logic ctrl_sclk_pullup_en, // sclk pull
    input pad_cfg_pkg::slew_t ctrl_sclk_slew_sel, // sclk slew
    input logic device_address_bit_zero_pullup_en, // select pull
    input pad_cfg_pkg::drive_t ctrl_din_drive_sel // din drive
);
    import pad_cfg_pkg::*;
    logic wr;
    // low byte lane carries every live field
    assign wr = psel && penable && pwrite && pstrb[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("ready missing in access phase");
    a_quiet_idle: assert property (!(psel && penable) |-> !pready && !pslverr)
        else $error("response outside access phase");
    a_sclk_pull_write: assert property (wr && paddr == 18'h3de64
        |=> ctrl_sclk_pullup_en == $past(pwdata[4]))
        else $error("sclk pull not updated");
    a_sclk_slew_write: assert property (wr && paddr == 18'h3de64
        |=> ctrl_sclk_slew_sel == $past(pwdata[3:2]))
        else $error("sclk slew not updated");
    a_din_drive_write: assert property (wr && paddr == 18'h3de70
        |=> ctrl_din_drive_sel == $past(pwdata[1:0]))
        else $error("din drive not updated");
    a_select_pull_hold: assert property (!(psel && penable && pwrite)
        |=> $stable(device_address_bit_zero_pullup_en))
        else $error("select pull changed without write");
    a_misaligned_err: assert property (psel && penable
        && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_mapped_no_err: assert property (psel && penable
        && paddr == 18'h3de6c |-> !pslverr)
        else $error("mapped access refused");
    cover property (wr && paddr == 18'h3de64);
    cover property (psel && penable && pslverr);
    cover property (psel && penable && !pwrite);
endmodule : pad_cfg_sva
bind control_port_pad_config_regs pad_cfg_sva #(.ADDR_WIDTH(ADDR_WIDTH)) pad_cfg_sva_i (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .ctrl_sclk_pullup_en(ctrl_sclk_pullup_en), .ctrl_sclk_slew_sel(ctrl_sclk_slew_sel),
    .device_address_bit_zero_pullup_en(device_address_bit_zero_pullup_en),
    .ctrl_din_drive_sel(ctrl_din_drive_sel));

// [sim/control_port_pad_config_regs_tb.sv]
// self-checking bench for the pad configuration register bank
`timescale 1ns/1ns
module control_port_pad_config_regs_tb;
    import pad_cfg_pkg::*;
    localparam logic [15:0] RST [5] = '{16'h0008, 16'h0008, 16'h0008, 16'h0018, 16'h0018};
    logic clk, reset, psel, penable, pwrite, pready, pslverr, e, pu [5];
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    slew_t sl [5];
    drive_t dr [5];
    logic [15:0] sh [5];
    int errCount = 0;
    int samplesChecked = 0;
    control_port_pad_config_regs control_port_pad_config_regs_i (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .audio_tx_out_pin_pulldown_en(pu[0]),
        .audio_tx_out_pin_slew_sel(sl[0]), .audio_tx_out_pin_drive_sel(dr[0]),
        .ctrl_sclk_pullup_en(pu[1]), .ctrl_sclk_slew_sel(sl[1]), .ctrl_sclk_drive_sel(dr[1]),
        .ctrl_dout_pullup_en(pu[2]), .ctrl_dout_slew_sel(sl[2]), .ctrl_dout_drive_sel(dr[2]),
        .device_address_bit_zero_pullup_en(pu[3]), .device_address_bit_zero_slew_sel(sl[3]),
        .device_address_bit_zero_drive_sel(dr[3]), .ctrl_din_pullup_en(pu[4]),
        .ctrl_din_slew_sel(sl[4]), .ctrl_din_drive_sel(dr[4]));
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    function automatic logic [17:0] ad(input int i);
        return {16'hf798 + 16'(i), 2'h0};
    endfunction : ad
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    // called just after a rising edge; returns one edge after the release
    task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : xfer
    task automatic chk_all(input logic [15:0] v [5]);
        for (int i = 0; i < 5; i++) begin
            xfer(1'h0, ad(i), 32'h0, 4'h0);
            chk("readback", r, {16'h0, v[i]});
            chk("error flag", {31'h0, e}, 32'h0);
            chk("pad outputs", {27'h0, pu[i], sl[i], dr[i]}, {27'h0, v[i][4:0]});
        end
    endtask : chk_all
    task automatic wrap_up;
        if (errCount == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #50000;
        errCount++;
        wrap_up();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        reset = 1'h1;
        repeat (20) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        chk_all(RST);
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 5; i++) begin
                sh[i] = {11'h52d ^ 11'(k * 3 + i), k[0], 2'(k), 2'(3 - k)};
                xfer(1'h1, ad(i), {16'hffff, sh[i]}, 4'h3);
            end
            chk_all(sh);
        end
        // upper lane alone must leave the live fields untouched
        xfer(1'h1, ad(3), 32'h0000ffff, 4'h2);
        sh[3][15:8] = 8'hff;
        xfer(1'h0, ad(5), 32'h0, 4'h0);
        chk("unmapped error", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
        xfer(1'h1, ad(0) + 18'h1, 32'h1f, 4'h3);
        chk("misaligned error", {31'h0, e}, 32'h1);
        chk_all(sh);
        reset <= 1'h1;
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        chk_all(RST);
        wrap_up();
    end
endmodule : control_port_pad_config_regs_tb
